// *** core/wdg_consts.svh ***
// Constants of the watchdog block: register offsets, field positions,
// reset values and timing figures.
// Assumes inclusion by bare name from the core folder.
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

`define WDG_ADDR_W 16
`define WDG_OPT_ADDR 16'h0081
`define WDG_CFG_ADDR 16'h2007
`define WDG_STAT_ADDR 16'h0003
`define WDG_OPT_RST 8'hff
`define WDG_ASSIGN_BIT 3
`define WDG_RATIO_MSB 2
`define WDG_FUSE_EN_BIT 2
`define WDG_STAT_TIMEOUT_BIT 4
`define WDG_STAT_PDOWN_BIT 3
`define WDG_PERIOD_US 18000
`define WDG_CLK_MHZ 25
`define WDG_PERIOD_CYC (`WDG_PERIOD_US * `WDG_CLK_MHZ)

`endif

// *** core/wdg_pkg.sv ***
// Types shared by the watchdog block.
// Assumes nothing beyond a SystemVerilog compiler.
package wdg_pkg;
  typedef enum logic {WDG_AWAKE, WDG_ASLEEP} wdg_mode_t;
endpackage

// *** core/wdg_counter.sv ***
// Up-counter with clear that wraps at a limit and flags the wrap.
// Assumes clear and count inputs synchronous to clk.
`timescale 1ns/1ps
module wdg_counter
  import wdg_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic clr,
  input wire logic inc,
  input wire logic [W-1:0] limit,
  // Status.
  output logic wrap
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  always_comb begin
    wrap = inc && (count_r >= limit);
    count_nxt = count_r;
    if (clr || wrap) begin
      count_nxt = '0;
    end else if (inc) begin
      count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule

// *** core/wdg_regs.sv ***
// Register port of the watchdog: control register, fuse word and status.
// Assumes one-cycle strobes; read data stands in the cycle after the read.
`timescale 1ns/1ps
`include "wdg_consts.svh"
module wdg_regs
  import wdg_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [`WDG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Block side.
  input wire logic reload,
  input wire logic [7:0] fuse_word,
  input wire logic timeout_flag,
  input wire logic pdown_flag,
  output logic [7:0] opt_r
);
  logic [7:0] opt_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    opt_nxt = opt_r;
    if (reload) begin
      opt_nxt = `WDG_OPT_RST;
    end else if (reg_wr && reg_addr == `WDG_OPT_ADDR) begin
      opt_nxt = reg_wdata;
    end
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `WDG_OPT_ADDR: rdata_nxt = opt_r;
        `WDG_CFG_ADDR: rdata_nxt = fuse_word;
        `WDG_STAT_ADDR: begin
          rdata_nxt[`WDG_STAT_TIMEOUT_BIT] = timeout_flag;
          rdata_nxt[`WDG_STAT_PDOWN_BIT] = pdown_flag;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_r <= `WDG_OPT_RST;
      rdata_r <= 8'h00;
    end else begin
      opt_r <= opt_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule

// *** core/wdg_top.sv ***
// Watchdog timer with shared prescaler, its control register and flags.
// Assumes CPU event inputs are one-cycle pulses synchronous to clk.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "wdg_consts.svh"
// Behaviour
// - Watchdog tick runs on, also during sleep.
// - Time-out while running requests device reset.
// - Time-out while asleep wakes, no reset.
// - Fuse bit 2 clear disables watchdog.
// - Base time-out period is 18 ms.
// - Assigned prescaler lengthens period up to 128.
// - Clear or sleep resets counter and prescaler.
// - Every time-out clears the time-out flag.
// - Control register resets to all ones.
// - Assign select bit 3, ratio bits 2:0.
// - Sleep clears count, power-down flag; sets time-out flag.
// - Any wake-up clears the watchdog count.
module wdg_top
  import wdg_pkg::*;
#(
  parameter int PERIOD_CYC = `WDG_PERIOD_CYC,
  parameter int BASE_W = 20,
  parameter int PRE_W = 7
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [`WDG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Configuration fuses.
  input wire logic [7:0] fuse_config_word,
  // CPU events.
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic wake_event,
  // Results.
  output logic device_reset_req,
  output logic wake_req,
  output logic sleeping,
  output logic timeout_status_flag,
  output logic powerdown_flag
);
  logic rst_meta_r;
  logic rst_sync_r;
  logic [7:0] fuse_r;
  logic [7:0] opt_r;
  wdg_mode_t mode_r;
  wdg_mode_t mode_nxt;
  logic timeout_r;
  logic timeout_nxt;
  logic pdown_r;
  logic pdown_nxt;
  logic rstreq_r;
  logic rstreq_nxt;
  logic wake_r;
  logic wake_nxt;
  logic enabled;
  logic assigned;
  logic clr_all;
  logic base_wrap;
  logic pre_wrap;
  logic expire;
  logic [PRE_W-1:0] pre_limit;

  // Reset release through two flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Fuses are static; they are sampled every cycle after reset.
  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fuse_r <= 8'h00;
    end else begin
      fuse_r <= fuse_config_word;
    end
  end

  assign enabled = fuse_r[`WDG_FUSE_EN_BIT];
  assign assigned = opt_r[`WDG_ASSIGN_BIT];
  assign pre_limit = PRE_W'((1 << opt_r[`WDG_RATIO_MSB:0]) - 1);

  // The tick source is never gated by sleep.
  wdg_counter #(.W(BASE_W)) u_base (
    .clk(clk),
    .rst_n(rst_sync_r),
    .clr(clr_all),
    .inc(enabled),
    .limit(BASE_W'(PERIOD_CYC - 1)),
    .wrap(base_wrap)
  );

  wdg_counter #(.W(PRE_W)) u_pre (
    .clk(clk),
    .rst_n(rst_sync_r),
    .clr(clr_all || !assigned),
    .inc(base_wrap && assigned),
    .limit(pre_limit),
    .wrap(pre_wrap)
  );

  assign expire = assigned ? pre_wrap : base_wrap;

  // Any event that clears the counting chain.
  assign clr_all = watchdog_clear_instr || sleep_instr || expire
    || (mode_r == WDG_ASLEEP && wake_event);

  always_comb begin
    mode_nxt = mode_r;
    timeout_nxt = timeout_r;
    pdown_nxt = pdown_r;
    rstreq_nxt = 1'b0;
    wake_nxt = 1'b0;
    if (watchdog_clear_instr) begin
      timeout_nxt = 1'b1;
      pdown_nxt = 1'b1;
    end
    unique case (mode_r)
      WDG_AWAKE: begin
        if (sleep_instr) begin
          mode_nxt = WDG_ASLEEP;
          pdown_nxt = 1'b0;
          timeout_nxt = 1'b1;
        end
        if (expire) begin
          rstreq_nxt = 1'b1;
          mode_nxt = WDG_AWAKE;
        end
      end
      WDG_ASLEEP: begin
        if (expire || wake_event) begin
          mode_nxt = WDG_AWAKE;
          wake_nxt = 1'b1;
        end
      end
    endcase
    // A time-out in the same cycle as a clear still marks the flag.
    if (expire) begin
      timeout_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mode_r <= WDG_AWAKE;
      timeout_r <= 1'b1;
      pdown_r <= 1'b1;
      rstreq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      timeout_r <= timeout_nxt;
      pdown_r <= pdown_nxt;
      rstreq_r <= rstreq_nxt;
      wake_r <= wake_nxt;
    end
  end

  // A watchdog reset also returns the control register to all ones.
  wdg_regs u_regs (
    .clk(clk),
    .rst_n(rst_sync_r),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reload(rstreq_r),
    .fuse_word(fuse_r),
    .timeout_flag(timeout_r),
    .pdown_flag(pdown_r),
    .opt_r(opt_r)
  );

  assign device_reset_req = rstreq_r;
  assign wake_req = wake_r;
  assign sleeping = (mode_r == WDG_ASLEEP);
  assign timeout_status_flag = timeout_r;
  assign powerdown_flag = pdown_r;
endmodule

// *** testbench/wdg_properties.sv ***
// Port checker of the watchdog block.
// Assumes the bench period of 8 cycles or more.
`timescale 1ns/1ps
module wdg_properties #(
  parameter int PERIOD_CYC = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register read side.
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Fuses and CPU events.
  input wire logic [7:0] fuse_config_word,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  // Results.
  input wire logic device_reset_req,
  input wire logic wake_req,
  input wire logic sleeping,
  input wire logic timeout_status_flag,
  input wire logic powerdown_flag
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_sleep_go;
    sleep_instr && !sleeping;
  endsequence
  sequence s_fuse_off;
    !fuse_config_word[2] [*3];
  endsequence
  a_sleep_entry: assert property (s_sleep_go |=>
    sleeping && !powerdown_flag && timeout_status_flag) else $error("sleep entry");
  a_reset_pulse: assert property (device_reset_req |=> !device_reset_req)
    else $error("reset pulse");
  a_reset_awake: assert property (device_reset_req |-> !$past(sleeping))
    else $error("reset while asleep");
  a_wake_asleep: assert property (wake_req |-> $past(sleeping) && !sleeping)
    else $error("wake");
  a_reset_flag: assert property (device_reset_req |-> !timeout_status_flag)
    else $error("flag");
  a_fuse_off: assert property (s_fuse_off |-> !device_reset_req)
    else $error("fuse");
  a_clear_guard: assert property (watchdog_clear_instr |-> ##2 !device_reset_req [*6])
    else $error("clear");
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata");
endmodule
bind wdg_top wdg_properties #(.PERIOD_CYC(PERIOD_CYC)) u_props (
  .clk(clk),
  .rst_n(rst_n),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .fuse_config_word(fuse_config_word),
  .watchdog_clear_instr(watchdog_clear_instr),
  .sleep_instr(sleep_instr),
  .device_reset_req(device_reset_req),
  .wake_req(wake_req),
  .sleeping(sleeping),
  .timeout_status_flag(timeout_status_flag),
  .powerdown_flag(powerdown_flag)
);

// *** testbench/watchdog_timer_with_prescaler_bench.sv ***
// Self-checking bench of the watchdog block.
// Assumes the checker file bound beside it.
`timescale 1ns/1ps
`include "wdg_consts.svh"
module watchdog_timer_with_prescaler_bench;
  localparam int PER = 8;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, wake_event = 0;
  logic watchdog_clear_instr = 0, sleep_instr = 0;
  logic [`WDG_ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = 8'h00, fuse_config_word = 8'hff, reg_rdata;
  logic device_reset_req, wake_req, sleeping, timeout_status_flag, powerdown_flag;
  logic [31:0] d;
  int errors = 0, num_checks = 0, n0, n, rc = 0;
  wdg_top #(.PERIOD_CYC(PER)) DUT (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .fuse_config_word(fuse_config_word),
    .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_instr(sleep_instr),
    .wake_event(wake_event),
    .device_reset_req(device_reset_req),
    .wake_req(wake_req),
    .sleeping(sleeping),
    .timeout_status_flag(timeout_status_flag),
    .powerdown_flag(powerdown_flag)
  );
  always #20 clk = ~clk;
  always @(negedge clk) if (device_reset_req === 1'b1) rc++;
  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 d = {24'h0, reg_rdata};
  endtask
  task ev(input int k);
    @(posedge clk) {watchdog_clear_instr, sleep_instr, wake_event} <= 3'b100 >> k;
    @(posedge clk) {watchdog_clear_instr, sleep_instr, wake_event} <= 3'b000;
  endtask
  // Counts cycles until a wake or reset pulse, giving up after 1200.
  task meas(input logic w);
    #1 n = 0;
    while ((w ? wake_req : device_reset_req) !== 1'b1 && n < 1200) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`WDG_OPT_ADDR);
    chk(d, `WDG_OPT_RST);
    wr(`WDG_CFG_ADDR, 8'h00);
    rd(`WDG_CFG_ADDR);
    chk(d, 8'hff);
    rd(16'h0055);
    chk(d, 0);
    $display("registers done");
    for (int i = 0; i < 10; i++) begin
      wr(`WDG_OPT_ADDR, i < 2 ? 8'(7 * i) : 8'(i + 6));
      ev(0);
      meas(0);
      if (i == 0) n0 = n;
      chk(n, i < 2 ? n0 : n0 + PER * ((1 << (i - 2)) - 1));
      chk(timeout_status_flag, 0);
      rd(`WDG_OPT_ADDR);
      chk(d, `WDG_OPT_RST);
    end
    chk(n0 >= PER && n0 <= PER + 2, 1);
    $display("periods done");
    wr(`WDG_OPT_ADDR, 8'h09);
    // Clear first: the divide-by-two period is 16 cycles from the last clear.
    repeat (4) begin
      ev(0);
      repeat (10) @(posedge clk);
    end
    wr(`WDG_OPT_ADDR, 8'h00);
    ev(1);
    meas(1);
    chk(n, n0);
    chk(sleeping, 0);
    chk(timeout_status_flag, 0);
    chk(rc, 10);
    ev(1);
    rd(`WDG_STAT_ADDR);
    chk(d, 8'h10);
    repeat (2) @(posedge clk);
    ev(2);
    meas(1);
    meas(0);
    chk(n, n0);
    $display("sleep done");
    @(posedge clk) fuse_config_word <= 8'hfb;
    // The reset pulse is counted on the falling edge, so look one edge later.
    chk(rc, 11);
    ev(0);
    meas(0);
    chk(n, 1200);
    rd(`WDG_CFG_ADDR);
    chk(d, 8'hfb);
    $display("fuse done");
    final_report;
  end
endmodule
